//--- dahp_map.svh
/*
  constants of the acknowledge-style host port: field positions, reset
  values and frame figures. assumes inclusion by dahp_pkg and the top.
*/
`ifndef DAHP_MAP_SVH
`define DAHP_MAP_SVH
`define DAHP_OP2_SEL_LO   0
`define DAHP_OP3_SEL_LO   2
`define DAHP_OP4_EN       4
`define DAHP_ISR_TXA      0
`define DAHP_ISR_RXA      1
`define DAHP_ISR_TXB      4
`define DAHP_ISR_RXB      5
`define DAHP_PIN_RST      8'hff
`define DAHP_ACK_RST      1'b1
`define DAHP_DATA_BITS    8
`define DAHP_STOP_CNT     4'h8
`define DAHP_FRAME_BITS   4'ha
`define DAHP_FIFO_DEPTH   8
`endif

//--- dahp_pkg.sv
/*
  types of the host port. assumes dahp_map.svh supplies the numbers.
*/
`include "dahp_map.svh"
package dahp_pkg;
  // one host write handed to the core
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } dahp_wr_t;
  // synchronised host pins
  typedef struct packed {
    logic       cs_n;
    logic       rw;
    logic       iack_n;
    logic [3:0] addr;
    logic [7:0] data;
    logic [1:0] rx;
  } dahp_pins_t;
  // bus cycle sequencer
  typedef enum logic [1:0] {
    DAHP_IDLE = 2'b00,
    DAHP_ACT  = 2'b01,
    DAHP_HOLD = 2'b10
  } dahp_state_t;
endpackage

//--- dahp_port.sv
/*
  host port logic: pin sync, bus sequencer, write fifo, serial lines and
  output pin multiplexer. assumes one free running clock and a core
  that owns the registers and answers reads in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dahp_map.svh"

module dahp_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = `DAHP_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage words
  logic [AW-1:0]    wr_ptr;       // next free slot
  logic [AW-1:0]    rd_ptr;       // oldest word
  logic [AW:0]      count;        // words held
  logic             do_wr;        // accepted push
  logic             do_rd;        // accepted pop

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign do_wr       = i_in_valid & o_in_ready;
  assign do_rd       = o_out_valid & i_out_ready;

  // storage, no reset needed on data
  always_ff @(posedge i_sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers and fill level; depth is a power of two so pointers wrap
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

module dahp_port (
  // clock and reset (reset pin)
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  // host bus pins
  input  wire logic             i_chip_select_n,
  input  wire logic             i_read_write_line,
  input  wire logic [3:0]       i_reg_select,
  input  wire logic             i_int_ack_in_n,
  input  wire logic [7:0]       i_host_bus,
  output logic      [7:0]       o_host_bus,
  output logic                  o_host_bus_oe,
  output logic                  o_transfer_ack_n,
  output logic                  o_irq_out_n,
  output logic                  o_irq_out_oe,
  // serial lines
  input  wire logic             i_serial_in_chan_a,
  input  wire logic             i_serial_in_chan_b,
  output logic                  o_serial_out_chan_a,
  output logic                  o_serial_out_chan_b,
  // output port pins
  output logic      [7:0]       o_out_pin,
  output logic      [7:0]       o_out_pin_oe,
  // core register access
  output logic                  o_wr_valid,
  input  wire logic             i_wr_ready,
  output logic      [3:0]       o_wr_addr,
  output logic      [7:0]       o_wr_data,
  output logic                  o_rd_strobe,
  output logic      [3:0]       o_rd_addr,
  input  wire logic [7:0]       i_rd_data,
  input  wire logic [7:0]       i_int_vector,
  output logic                  o_core_rst_n,
  // core state feeding the pins
  input  wire logic [7:0]       i_isr,
  input  wire logic [7:0]       i_imr,
  input  wire logic [7:0]       i_opr,
  input  wire logic [7:0]       i_output_port_config,
  input  wire logic [1:0]       i_rts_mode,
  input  wire logic [1:0]       i_rts_on,
  input  wire logic [4:0]       i_clk_taps,
  input  wire logic             i_ct_out,
  // per channel serial control, index 0 is channel a
  input  wire logic [1:0]       i_tx_enable,
  input  wire logic [1:0]       i_loopback,
  input  wire logic [1:0]       i_bit_tick,
  input  wire logic [1:0]       i_rx_tick,
  input  wire logic [1:0]       i_tx_valid,
  output logic      [1:0]       o_tx_ready,
  input  wire logic [1:0][7:0]  i_tx_byte,
  output logic      [1:0]       o_rx_valid,
  output logic      [1:0][7:0]  o_rx_byte
);
  dahp_pkg::dahp_pins_t  pin_meta;   // first sync stage only
  dahp_pkg::dahp_pins_t  pin_s;      // second stage, safe to use
  dahp_pkg::dahp_state_t state;      // bus sequencer
  dahp_pkg::dahp_wr_t    wr_in;      // write entering the fifo
  dahp_pkg::dahp_wr_t    wr_out;     // write leaving the fifo
  logic                  cyc;        // host cycle in progress
  logic                  is_iack;    // vector cycle
  logic                  is_read;    // read cycle
  logic                  push;       // write offered to fifo
  logic                  fifo_ready; // fifo has room
  logic                  drive;      // read data held for host
  logic                  rst_q;      // reset echo for the core
  logic [7:0]            next_pin;   // pin levels
  logic [7:0]            next_oe;    // pin enables
  logic [3:0]            irq_src;    // isr bits for pins 4..7
  logic [1:0]            tx_line;    // serial outputs

  // two-stage synchroniser on every host and serial input pin
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_meta <= '{cs_n: 1'b1, rw: 1'b1, iack_n: 1'b1, rx: 2'b11, default: '0};
      pin_s    <= '{cs_n: 1'b1, rw: 1'b1, iack_n: 1'b1, rx: 2'b11, default: '0};
    end else begin
      pin_meta <= '{cs_n: i_chip_select_n, rw: i_read_write_line,
                    iack_n: i_int_ack_in_n, addr: i_reg_select,
                    data: i_host_bus,
                    rx: {i_serial_in_chan_b, i_serial_in_chan_a}};
      pin_s    <= pin_meta;
    end
  end

  // cycle decode from synchronised pins
  assign cyc     = ~pin_s.cs_n | ~pin_s.iack_n;
  assign is_iack = ~pin_s.iack_n;
  assign is_read = pin_s.rw;

  // bus sequencer: idle, act (the two sync edges have passed), hold
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= dahp_pkg::DAHP_IDLE;
    end else begin
      case (state)
        dahp_pkg::DAHP_IDLE: begin
          if (cyc) begin
            state <= dahp_pkg::DAHP_ACT;
          end
        end
        dahp_pkg::DAHP_ACT: begin
          // withdrawn early: go back, no ack
          if (!cyc) begin
            state <= dahp_pkg::DAHP_IDLE;
          end else if (is_iack || is_read || fifo_ready) begin
            state <= dahp_pkg::DAHP_HOLD;
          end
        end
        dahp_pkg::DAHP_HOLD: begin
          if (!cyc) begin
            state <= dahp_pkg::DAHP_IDLE;
          end
        end
        default: begin
          state <= dahp_pkg::DAHP_IDLE;
        end
      endcase
    end
  end

  // acknowledge: low from the transfer until the cycle ends
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_transfer_ack_n <= `DAHP_ACK_RST;
    end else if (state == dahp_pkg::DAHP_ACT && cyc &&
                 (is_iack || is_read || fifo_ready)) begin
      o_transfer_ack_n <= 1'b0;
    end else if (!cyc) begin
      o_transfer_ack_n <= 1'b1;
    end
  end

  // read data or vector captured in the transfer cycle
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_host_bus <= '0;
      drive      <= 1'b0;
    end else if (state == dahp_pkg::DAHP_ACT && cyc && (is_iack || is_read)) begin
      o_host_bus <= is_iack ? i_int_vector : i_rd_data;
      drive      <= 1'b1;
    end else if (!cyc) begin
      drive      <= 1'b0;
    end
  end

  // bus floats whenever the cycle is not live
  assign o_host_bus_oe = drive & cyc;

  // read strobe to the core, address passed straight through
  assign o_rd_strobe = (state == dahp_pkg::DAHP_ACT) & cyc & is_read & ~is_iack;
  assign o_rd_addr   = pin_s.addr;

  // writes queue in the fifo; a full fifo stalls the ack, not the data
  assign push  = (state == dahp_pkg::DAHP_ACT) & cyc & ~is_read & ~is_iack;
  assign wr_in = '{addr: pin_s.addr, data: pin_s.data};

  dahp_fifo #(
    .WIDTH ($bits(dahp_pkg::dahp_wr_t)),
    .DEPTH (`DAHP_FIFO_DEPTH)
  ) u_wr_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (wr_in),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  (wr_out)
  );

  assign o_wr_addr = wr_out.addr;
  assign o_wr_data = wr_out.data;

  // reset echo so the core clears its registers and stops the timer
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= 1'b1;
    end
  end
  assign o_core_rst_n = rst_q;

  // interrupt request, open drain: only ever pulls low
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_out_oe <= 1'b0;
    end else begin
      o_irq_out_oe <= |(i_isr & i_imr);
    end
  end
  assign o_irq_out_n = 1'b0;

  // serial channels, one generate entry per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [9:0] tx_sh;    // stop, data, start
    logic [3:0] tx_cnt;   // bits left
    logic [7:0] rx_sh;    // assembled byte
    logic [3:0] rx_cnt;   // bits taken
    logic       rx_busy;  // inside a frame

    assign o_tx_ready[ch] = i_tx_enable[ch] & (tx_cnt == '0);

    // transmitter shifts right, so bit zero leaves first
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        tx_sh  <= '1;
        tx_cnt <= '0;
      end else if (o_tx_ready[ch] && i_tx_valid[ch]) begin
        tx_sh  <= {1'b1, i_tx_byte[ch], 1'b0};
        tx_cnt <= `DAHP_FRAME_BITS;
      end else if (i_bit_tick[ch] && tx_cnt != '0) begin
        tx_sh  <= {1'b1, tx_sh[9:1]};
        tx_cnt <= tx_cnt - 1'b1;
      end
    end

    // mark while disabled, idle or looped back
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        tx_line[ch] <= 1'b1;
      end else if (!i_tx_enable[ch] || i_loopback[ch] || tx_cnt == '0) begin
        tx_line[ch] <= 1'b1;
      end else begin
        tx_line[ch] <= tx_sh[0];
      end
    end

    // receiver fills from the top, so the first bit lands in bit zero
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        rx_busy <= 1'b0;
        rx_cnt  <= '0;
        rx_sh   <= '0;
      end else if (i_rx_tick[ch]) begin
        if (!rx_busy) begin
          rx_busy <= ~pin_s.rx[ch];
          rx_cnt  <= '0;
        end else if (rx_cnt == `DAHP_STOP_CNT) begin
          rx_busy <= 1'b0;
        end else begin
          rx_sh   <= {pin_s.rx[ch], rx_sh[7:1]};
          rx_cnt  <= rx_cnt + 1'b1;
        end
      end
    end

    // byte strobe at the stop bit; framing is left to the core
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        o_rx_valid[ch] <= 1'b0;
        o_rx_byte[ch]  <= '0;
      end else begin
        o_rx_valid[ch] <= i_rx_tick[ch] & rx_busy & (rx_cnt == `DAHP_STOP_CNT);
        o_rx_byte[ch]  <= rx_sh;
      end
    end
  end

  assign o_serial_out_chan_a = tx_line[0];
  assign o_serial_out_chan_b = tx_line[1];

  // interrupt sources for pins 4..7, open drain when selected
  assign irq_src = {i_isr[`DAHP_ISR_TXB], i_isr[`DAHP_ISR_TXA],
                    i_isr[`DAHP_ISR_RXB], i_isr[`DAHP_ISR_RXA]};

  // output pin multiplexer; port value is inverted onto the pin
  always_comb begin
    next_pin = ~i_opr;
    next_oe  = '1;
    // request-to-send, low when asserted
    for (int k = 0; k < 2; k++) begin
      if (i_rts_mode[k]) begin
        next_pin[k] = ~i_rts_on[k];
      end
    end
    // channel a clocks
    case (i_output_port_config[`DAHP_OP2_SEL_LO +: 2])
      2'h1:    next_pin[2] = i_clk_taps[0];
      2'h2:    next_pin[2] = i_clk_taps[1];
      2'h3:    next_pin[2] = i_clk_taps[2];
      default: next_pin[2] = ~i_opr[2];
    endcase
    // timer pulls low only; channel b clocks
    case (i_output_port_config[`DAHP_OP3_SEL_LO +: 2])
      2'h1: begin
        next_pin[3] = 1'b0;
        next_oe[3]  = ~i_ct_out;
      end
      2'h2:    next_pin[3] = i_clk_taps[3];
      2'h3:    next_pin[3] = i_clk_taps[4];
      default: next_pin[3] = ~i_opr[3];
    endcase
    // interrupt pins pull low while their bit is set
    for (int k = 0; k < 4; k++) begin
      if (i_output_port_config[`DAHP_OP4_EN + k]) begin
        next_pin[4+k] = 1'b0;
        next_oe[4+k]  = irq_src[k];
      end
    end
  end

  // pin registers; driven high throughout reset
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_out_pin    <= `DAHP_PIN_RST;
      o_out_pin_oe <= `DAHP_PIN_RST;
    end else begin
      o_out_pin    <= next_pin;
      o_out_pin_oe <= next_oe;
    end
  end
endmodule

`default_nettype wire

//--- dahp_port_sva.sv
/*
  checker for the host port pins of dahp_port.
  assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module dahp_port_sva (
  // clock and reset
  input wire logic       i_sys_clk,
  input wire logic       i_rstn,
  // host pins
  input wire logic       i_chip_select_n,
  input wire logic       i_read_write_line,
  input wire logic       i_int_ack_in_n,
  input wire logic       o_host_bus_oe,
  input wire logic       o_transfer_ack_n,
  input wire logic       o_irq_out_oe,
  input wire logic       o_rd_strobe,
  // lines and pins
  input wire logic       o_serial_out_chan_a,
  input wire logic [7:0] o_out_pin,
  input wire logic [7:0] o_out_pin_oe,
  // core state
  input wire logic [7:0] i_isr,
  input wire logic [7:0] i_imr,
  input wire logic [7:0] i_opr,
  input wire logic [7:0] i_output_port_config,
  input wire logic [1:0] i_rts_mode,
  input wire logic [1:0] i_tx_enable,
  input wire logic [1:0] i_loopback
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // raw cycle request, before the sync flops
  wire logic cyc = !i_chip_select_n || !i_int_ack_in_n;
  // host has let go for long enough to clear the sync flops
  sequence s_cyc_gone;
    !cyc [*4];
  endsequence
  AST_ACK_LATE: assert property ($fell(o_transfer_ack_n) |-> $past(cyc, 3) && $past(cyc, 4))
    else $error("ack before two edges of select");
  AST_ACK_STANDS: assert property (!o_transfer_ack_n && cyc && $past(cyc) |=> !o_transfer_ack_n)
    else $error("ack dropped while select held");
  AST_ACK_OFF: assert property (s_cyc_gone |-> o_transfer_ack_n)
    else $error("ack held after select released");
  AST_FLOAT: assert property (s_cyc_gone |-> !o_host_bus_oe)
    else $error("bus driven without select");
  AST_OE_CAUSE: assert property (o_host_bus_oe |-> $past(cyc, 2) && ($past(i_read_write_line, 2) || !$past(i_int_ack_in_n, 2)))
    else $error("bus driven outside a read");
  AST_STROBE_ACK: assert property (o_rd_strobe |=> !o_transfer_ack_n)
    else $error("read strobe without ack");
  AST_IRQ: assert property (1'b1 |=> o_irq_out_oe == |($past(i_isr) & $past(i_imr)))
    else $error("irq does not follow masked status");
  AST_TX_MARK: assert property ((!i_tx_enable[0] || i_loopback[0]) |=> o_serial_out_chan_a)
    else $error("tx line not at mark");
  AST_PIN0_GP: assert property (!i_rts_mode[0] |=> o_out_pin[0] == !$past(i_opr[0]))
    else $error("pin 0 not inverse of port value");
  AST_PIN4_IRQ: assert property (i_output_port_config[4] |=> o_out_pin_oe[4] == $past(i_isr[1]))
    else $error("pin 4 not receiver irq");
  AST_PIN6_IRQ: assert property (i_output_port_config[6] |=> o_out_pin_oe[6] == $past(i_isr[0]))
    else $error("pin 6 not transmitter irq");
endmodule
bind dahp_port dahp_port_sva i_dahp_port_sva (.i_sys_clk, .i_rstn, .i_chip_select_n,
  .i_read_write_line, .i_int_ack_in_n, .o_host_bus_oe, .o_transfer_ack_n, .o_irq_out_oe,
  .o_rd_strobe, .o_serial_out_chan_a, .o_out_pin, .o_out_pin_oe, .i_isr, .i_imr, .i_opr,
  .i_output_port_config, .i_rts_mode, .i_tx_enable, .i_loopback);
`default_nettype wire

//--- dahp_host.sv
/*
  host processor model on the acknowledge bus.
  assumes the bench resolves the data bus and calls cycle().
*/
`timescale 1ns/1ps
`default_nettype none
module dahp_host (
  // clock
  input  wire logic       i_sys_clk,
  // answers from the device
  input  wire logic       i_ack_n,
  input  wire logic [7:0] i_bus,
  // host pins
  output logic            o_cs_n,
  output logic            o_rw,
  output logic            o_iack_n,
  output logic      [3:0] o_addr,
  output logic      [7:0] o_data
);
  initial begin
    o_cs_n   = 1'b1;
    o_rw     = 1'b1;
    o_iack_n = 1'b1;
    o_addr   = 4'h0;
    o_data   = 8'h00;
  end
  // kind 0 read, 1 write, 2 vector; abort drops select after one edge
  task automatic cycle(input logic [1:0] kind, input bit abort, input logic [3:0] a,
                       input logic [7:0] d, output logic [7:0] rd, output bit acked);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    o_rw   <= (kind != 2'd1);
    o_addr <= a;
    o_data <= d;
    if (kind == 2'd2) o_iack_n <= 1'b0;
    else o_cs_n <= 1'b0;
    // hold everything until ack is seen, bounded
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (!abort && i_ack_n !== 1'b0 && n < 100);
    acked = (i_ack_n === 1'b0);
    rd = i_bus;
    o_cs_n   <= 1'b1;
    o_iack_n <= 1'b1;
    // released lines show garbage, not the last value
    o_addr <= ~a;
    o_data <= ~d;
    repeat (6) @(posedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

//--- tb.sv
/*
  self-checking bench for dahp_port with a host model.
  assumes the core side is played by the bench itself.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic             clk, rstn, wr_ready, ct_out, rx_a, rx_b;
  logic [7:0]       interrupt_status_reg, interrupt_mask_reg, output_port_value, output_port_config, vec, rd;
  logic [1:0]       rts_mode, rts_on, tx_en, loopb, tick, rx_tick, tx_valid;
  logic [4:0]       taps;
  logic [1:0][7:0]  tx_byte;
  logic [3:0]       rd_seen;
  logic [11:0]      popped[$];
  int               fails, n_tests, ncyc, ack_lo, i, n_rx;
  bit               ok;
  wire logic [7:0]  bus_o, bus, h_data, pins, pins_oe, wr_data, rd_data;
  wire logic [3:0]  h_addr, wr_addr, rd_addr;
  wire logic [1:0]  tx_ready;
  wire logic        h_cs_n, h_rw, h_iack_n, bus_oe, ack_n, irq_oe, txa, txb;
  wire logic        wr_valid, rd_strobe, core_rstn, irq_n;
  wire logic [1:0]  rx_valid;
  wire logic [1:0][7:0] rx_byte;
  // device wins the bus when it drives, host otherwise
  assign bus = bus_oe ? bus_o : h_data;
  // core answers reads with a pattern tied to the address
  assign rd_data = {4'ha, rd_addr};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dahp_host i_dahp_host (.i_sys_clk(clk), .i_ack_n(ack_n), .i_bus(bus), .o_cs_n(h_cs_n),
    .o_rw(h_rw), .o_iack_n(h_iack_n), .o_addr(h_addr), .o_data(h_data));
  dahp_port i_dahp_port (.i_sys_clk(clk), .i_rstn(rstn), .i_chip_select_n(h_cs_n),
    .i_read_write_line(h_rw), .i_reg_select(h_addr), .i_int_ack_in_n(h_iack_n),
    .i_host_bus(bus), .o_host_bus(bus_o), .o_host_bus_oe(bus_oe), .o_transfer_ack_n(ack_n),
    .o_irq_out_n(irq_n), .o_irq_out_oe(irq_oe), .i_serial_in_chan_a(rx_a),
    .i_serial_in_chan_b(rx_b), .o_serial_out_chan_a(txa), .o_serial_out_chan_b(txb),
    .o_out_pin(pins), .o_out_pin_oe(pins_oe), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_strobe(rd_strobe), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data), .i_int_vector(vec), .o_core_rst_n(core_rstn), .i_isr(interrupt_status_reg),
    .i_imr(interrupt_mask_reg),
    .i_opr(output_port_value), .i_output_port_config(output_port_config), .i_rts_mode(rts_mode), .i_rts_on(rts_on), .i_clk_taps(taps),
    .i_ct_out(ct_out), .i_tx_enable(tx_en), .i_loopback(loopb), .i_bit_tick(tick),
    .i_rx_tick(rx_tick), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_byte(tx_byte),
    .o_rx_valid(rx_valid), .o_rx_byte(rx_byte));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // watchers: strobe address, drained words, ack cycles, hang limit
  always @(posedge clk) begin
    ncyc++;
    if (rd_strobe === 1'b1) rd_seen <= rd_addr;
    if (wr_valid === 1'b1 && wr_ready) popped.push_back({wr_addr, wr_data});
    if (ack_n === 1'b0) ack_lo++;
    if (rx_valid !== 2'b00) n_rx++;
    if (ncyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  // every location answers with its own pattern
  task automatic t_read();
    for (i = 0; i < 16; i++) begin
      i_dahp_host.cycle(2'd0, 1'b0, i[3:0], 8'h00, rd, ok);
      chk("read ack", 16'h1, ok);
      chk("read data", {12'h00a, i[3:0]}, rd);
      chk("read addr", i[3:0], rd_seen);
    end
    i_dahp_host.cycle(2'd2, 1'b0, 4'h0, 8'h00, rd, ok);
    chk("vector", vec, rd);
    ack_lo = 0;
    i_dahp_host.cycle(2'd0, 1'b1, 4'h2, 8'h00, rd, ok);
    chk("withdrawn ack", 16'h0, ack_lo);
  endtask
  // fill the write fifo, stall, then drain in order
  task automatic t_write();
    wr_ready <= 1'b0;
    for (i = 0; i < 8; i++) begin
      i_dahp_host.cycle(2'd1, 1'b0, i[3:0], 8'h80 + i[7:0], rd, ok);
      chk("write ack", 16'h1, ok);
    end
    fork
      i_dahp_host.cycle(2'd1, 1'b0, 4'h8, 8'h88, rd, ok);
      begin
        repeat (30) @(posedge clk);
        chk("full ack", 16'h1, ack_n);
        wr_ready <= 1'b1;
      end
    join
    chk("late ack", 16'h1, ok);
    repeat (10) @(posedge clk);
    chk("drained", 16'h9, popped.size());
    for (i = 0; i < 9 && i < popped.size(); i++)
      chk("word", {i[3:0], 8'h80 + i[7:0]}, popped[i]);
  endtask
  // one bit period of channel a
  task automatic bit_tick();
    @(posedge clk) tick <= 2'b01;
    @(posedge clk) tick <= 2'b00;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_tx();
    tx_en <= 2'b01;
    repeat (3) @(posedge clk);
    chk("idle line", 16'h3, {txa, txb});
    tx_byte[0] <= 8'h35;
    tx_valid <= 2'b01;
    for (i = 0; i < 20 && tx_ready[0] !== 1'b1; i++) @(posedge clk);
    @(posedge clk) tx_valid <= 2'b00;
    // load edge has passed; the start bit reaches the line one edge later
    repeat (2) @(posedge clk);
    chk("start bit", 16'h0, txa);
    chk("tx busy", 16'h0, tx_ready[0]);
    for (i = 0; i < 8; i++) begin
      bit_tick();
      chk("data bit", (16'h0035 >> i) & 16'h0001, txa);
    end
    bit_tick();
    chk("stop bit", 16'h1, txa);
    bit_tick();
    chk("tx idle", 16'h1, tx_ready[0]);
    // a frame loaded in loopback must not reach the line
    loopb <= 2'b01;
    tx_byte[0] <= 8'h00;
    tx_valid <= 2'b01;
    @(posedge clk) tx_valid <= 2'b00;
    bit_tick();
    chk("loop mark", 16'h1, txa);
  endtask
  // status bit 4 set too, so a pin wired to the wrong bit shows up
  task automatic t_irq();
    interrupt_status_reg <= 8'h12;
    output_port_config <= 8'hf0;
    output_port_value <= 8'h01;
    repeat (3) @(posedge clk);
    chk("masked irq", 16'h0, irq_oe);
    interrupt_mask_reg <= 8'h02;
    repeat (3) @(posedge clk);
    chk("irq", 16'h1, irq_oe);
    chk("irq level", 16'h0, irq_n);
    chk("pin4 oe", 16'h1, pins_oe[4]);
    chk("pin5 oe", 16'h0, pins_oe[5]);
    chk("pin6 oe", 16'h0, pins_oe[6]);
    chk("pin0", 16'h0, pins[0]);
  endtask
  // one channel a bit: set the line, let it clear the sync flops, tick
  task automatic rx_bit(input logic b);
    @(posedge clk) rx_a <= b;
    repeat (3) @(posedge clk);
    rx_tick <= 2'b01;
    @(posedge clk) rx_tick <= 2'b00;
  endtask
  // idle tick, start, byte lsb first, stop; exactly one strobe expected
  task automatic t_rx();
    logic [7:0] pat;
    pat = 8'hc5;
    rx_bit(1'b1);
    rx_bit(1'b0);
    for (i = 0; i < 8; i++) rx_bit(pat[i]);
    rx_bit(1'b1);
    @(posedge clk);
    chk("rx strobe", 16'h1, rx_valid[0]);
    chk("rx byte", 16'h00c5, rx_byte[0]);
    @(posedge clk);
    chk("rx strobes", 16'h1, n_rx);
  endtask
  // pin multiplexer: request-to-send, clock taps, timer pull-down
  task automatic t_pins();
    output_port_value <= 8'h0c;
    output_port_config <= 8'h09;
    rts_mode <= 2'b01;
    rts_on <= 2'b01;
    taps <= 5'h09;
    repeat (3) @(posedge clk);
    chk("rts pins", 16'h2, pins[1:0]);
    chk("pin2 tx clock", 16'h1, pins[2]);
    chk("pin3 tx clock", 16'h1, pins[3]);
    output_port_config <= 8'h07;
    taps <= 5'h04;
    repeat (3) @(posedge clk);
    chk("pin2 rx clock", 16'h1, pins[2]);
    chk("pin3 timer oe", 16'h1, pins_oe[3]);
    chk("pin3 timer lvl", 16'h0, pins[3]);
    ct_out <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pin3 released", 16'h0, pins_oe[3]);
  endtask
  // reset in mid-run: pins high, lines mark, irq released, core held
  task automatic t_reset();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rst pins", 16'h00ff, pins);
    chk("rst lines", 16'h3, {txa, txb});
    chk("rst core", 16'h0, core_rstn);
    chk("rst irq", 16'h0, irq_oe);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("core run", 16'h1, core_rstn);
  endtask
  initial begin
    rstn = 1'b0;
    {wr_ready, ct_out, rx_a, rx_b} = 4'b1011;
    {interrupt_status_reg, interrupt_mask_reg, output_port_value, output_port_config} = 32'h0000_0000;
    vec = 8'h3c;
    {rts_mode, rts_on, tx_en, loopb, tick, rx_tick, tx_valid} = 14'h0000;
    taps = 5'h00;
    tx_byte = 16'h0000;
    repeat (10) @(posedge clk);
    chk("reset pins", 16'h00ff, pins);
    chk("reset lines", 16'h3, {txa, txb});
    chk("reset bus", 16'h0, bus_oe);
    chk("reset core", 16'h0, core_rstn);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_read();
    t_write();
    t_tx();
    t_rx();
    t_irq();
    t_pins();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
